// ===== rtl/mesa_map.vh
// Register map and timing constants for the MAC enable and station address
// block. Assumes inclusion by bare name from the rtl directory.
`ifndef MESA_MAP_VH
`define MESA_MAP_VH

// Register indices as printed; byte address is four times the index
`define MESA_IDX_CTRL        4'h1
`define MESA_IDX_ADDR_UPPER  4'h2
`define MESA_IDX_ADDR_LOWER  4'h3
`define MESA_IDX_STATUS      4'h7

// Control register field positions
`define MESA_CTRL_DEFERRAL_CHECK_ENABLE_BIT  5
`define MESA_CTRL_TRANSMITTER_ENABLE_BIT   3
`define MESA_CTRL_RECEIVER_ENABLE_BIT   2

// Reset values
`define MESA_RST_CTRL        32'h00000000
`define MESA_RST_ADDR_UPPER  32'h0000FFFF
`define MESA_RST_ADDR_LOWER  32'hFFFFFFFF
`define MESA_RST_ADDR_FIELD  16'hFFFF

// Configuration memory byte locations, in wire order of the address
`define MESA_EE_ADDR_B0      8'h01
`define MESA_EE_ADDR_B1      8'h02
`define MESA_EE_ADDR_B2      8'h03
`define MESA_EE_ADDR_B3      8'h04
`define MESA_EE_ADDR_B4      8'h05
`define MESA_EE_ADDR_B5      8'h06

// Deferral limit in bit times and one bit time in ns at 10 Mb/s
`define MESA_DEFER_BIT_TIMES 24288
`define MESA_BIT_TIME_NS     100
`define MESA_CLK_PERIOD_NS   100
`define MESA_DEFER_CYCLES    ((`MESA_DEFER_BIT_TIMES * `MESA_BIT_TIME_NS) / `MESA_CLK_PERIOD_NS)

`endif

// ===== rtl/mesa_sync.v
// Three flip-flop synchroniser for a level from outside the clock domain.
// A change counts once the second and third stages agree.
`timescale 1ns/1ns
module mesa_sync (
    input  wire i_sys_clk,
    input  wire i_rst,
    input  wire i_async,
    output reg  o_level
);
    reg [2:0] stage_q; // Sampling chain

    // Shift chain; first stage is read by the second stage only
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            stage_q <= 3'h0;
            o_level <= 1'b0;
        end else begin
            stage_q <= {stage_q[1:0], i_async};
            if (stage_q[1] == stage_q[2]) begin
                o_level <= stage_q[2];
            end
        end
    end
endmodule // mesa_sync

// ===== rtl/mesa_core.v
// MAC enable bits, deferral check and station address over APB.
// Assumes an APB master on i_sys_clk, 10 MHz, and a byte stream from the
// configuration memory controller on the same clock.
//
// Functional notes
// - Deferral timer restarts from zero every deferral
// - Check disabled: defer indefinitely, never abort
// - Transmit enable set: frames go to PHY
// - Transmit enable clear: no frame starts
// - Receive enable set: accept PHY frames
// - Upper register holds address bits 47:32
// - Programmed memory at power-on loads address
// - Locations 0x05, 0x06 fill upper bytes
// - Host writes address after initialization only
// - Check enabled: abort after 24288 bit times
// - Locations 0x01-0x04 fill lower register
// - First wire byte is lower bits 7:0
`timescale 1ns/1ns
`include "mesa_map.vh"
module mesa_core #(
    parameter DEFER_LIMIT = `MESA_DEFER_CYCLES
) (
    input  wire        i_sys_clk,
    input  wire        i_rst,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    input  wire        i_ee_valid,
    input  wire [7:0]  i_ee_loc,
    input  wire [7:0]  i_ee_byte,
    input  wire        i_ee_done,
    input  wire        i_crs,
    input  wire        i_tx_frame_ready,
    input  wire        i_tx_collision,
    input  wire        i_rx_frame_valid,
    output reg         o_tx_start,
    output reg         o_tx_abort,
    output reg         o_rx_accept,
    output reg         o_tx_enabled,
    output reg         o_rx_enabled,
    output reg  [7:0]  o_wire_byte,
    output reg         o_wire_valid,
    input  wire        i_wire_next
);
    reg        deferral_check_enable_q; // Deferral check on
    reg        transmitter_enable_q;    // Transmitter on
    reg        receiver_enable_q;       // Receiver on
    reg [15:0] station_address_upper_q; // Address bits 47:32
    reg [31:0] station_address_lower_q; // Address bits 31:0
    reg        init_done_q;             // Power-on load finished
    reg [14:0] defer_cnt_q;             // Deferral bit time counter
    reg        abort_seen_q;            // Sticky abort, status
    reg [2:0]  wire_idx_q;              // Address byte on wire
    wire       crs_s;                   // Synchronised carrier sense
    wire       access;                  // APB access phase
    wire [3:0] idx;                     // Register index
    wire       deferring;               // Ready but held off

    // Byte address to register index
    function [3:0] reg_index;
        input [7:0] addr;
        begin
            reg_index = addr[5:2];
        end
    endfunction

    // Carrier sense comes from the PHY pin domain
    mesa_sync u_crs_sync (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .i_async   (i_crs),
        .o_level   (crs_s)
    );

    assign access    = i_psel & i_penable;
    assign idx       = reg_index(i_paddr);
    assign deferring = transmitter_enable_q & i_tx_frame_ready & crs_s;

    // Register file, power-on load and APB answers
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            deferral_check_enable_q <= 1'b0;
            transmitter_enable_q    <= 1'b0;
            receiver_enable_q       <= 1'b0;
            station_address_upper_q <= `MESA_RST_ADDR_FIELD;
            station_address_lower_q <= `MESA_RST_ADDR_LOWER;
            init_done_q             <= 1'b0;
            o_prdata                <= 32'h00000000;
            o_pready                <= 1'b0;
            o_pslverr               <= 1'b0;
        end else begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            // Load only while a programmed memory streams bytes; with no
            // memory the controller only raises done and nothing loads
            if (!init_done_q && i_ee_valid) begin
                case (i_ee_loc)
                    `MESA_EE_ADDR_B0: begin
                        station_address_lower_q[7:0] <= i_ee_byte;
                    end
                    `MESA_EE_ADDR_B1: begin
                        station_address_lower_q[15:8] <= i_ee_byte;
                    end
                    `MESA_EE_ADDR_B2: begin
                        station_address_lower_q[23:16] <= i_ee_byte;
                    end
                    `MESA_EE_ADDR_B3: begin
                        station_address_lower_q[31:24] <= i_ee_byte;
                    end
                    `MESA_EE_ADDR_B4: begin
                        station_address_upper_q[7:0] <= i_ee_byte;
                    end
                    `MESA_EE_ADDR_B5: begin
                        station_address_upper_q[15:8] <= i_ee_byte;
                    end
                    default: ;
                endcase
            end
            if (i_ee_done) begin
                init_done_q <= 1'b1;
            end
            // One wait state: answer in the second access cycle
            // The write lands as pready is raised; the master sees pready
            // one edge later, and the raised pready blocks a second write
            if (access && !o_pready) begin
                o_pready <= 1'b1;
                if (idx == `MESA_IDX_CTRL) begin
                    if (i_pwrite) begin
                        deferral_check_enable_q <=
                            i_pwdata[`MESA_CTRL_DEFERRAL_CHECK_ENABLE_BIT];
                        transmitter_enable_q    <=
                            i_pwdata[`MESA_CTRL_TRANSMITTER_ENABLE_BIT];
                        receiver_enable_q       <=
                            i_pwdata[`MESA_CTRL_RECEIVER_ENABLE_BIT];
                    end
                    o_prdata <= {26'h0, deferral_check_enable_q, 1'b0,
                                 transmitter_enable_q, receiver_enable_q, 2'h0};
                end else if (idx == `MESA_IDX_ADDR_UPPER) begin
                    if (i_pwrite && init_done_q) begin
                        station_address_upper_q <= i_pwdata[15:0];
                    end
                    o_prdata <= {16'h0000, station_address_upper_q};
                end else if (idx == `MESA_IDX_ADDR_LOWER) begin
                    if (i_pwrite && init_done_q) begin
                        station_address_lower_q <= i_pwdata;
                    end
                    o_prdata <= station_address_lower_q;
                end else if (idx == `MESA_IDX_STATUS) begin
                    o_prdata <= {29'h0, abort_seen_q, crs_s, init_done_q};
                end else begin
                    // Unmapped address answers with an error
                    o_prdata  <= 32'h00000000;
                    o_pslverr <= 1'b1;
                end
            end
        end
    end

    // Deferral timer, transmit gating, receive gating
    // While the check is off the counter parks at the limit, so it never
    // wraps; turning the check on during a long deferral aborts at once
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            defer_cnt_q  <= 15'h0000;
            abort_seen_q <= 1'b0;
            o_tx_start   <= 1'b0;
            o_tx_abort   <= 1'b0;
            o_rx_accept  <= 1'b0;
            o_tx_enabled <= 1'b0;
            o_rx_enabled <= 1'b0;
        end else begin
            o_tx_start   <= 1'b0;
            o_tx_abort   <= 1'b0;
            o_tx_enabled <= transmitter_enable_q;
            o_rx_enabled <= receiver_enable_q;
            o_rx_accept  <= receiver_enable_q & i_rx_frame_valid;
            if (!deferring || i_tx_collision) begin
                defer_cnt_q <= 15'h0000;
            end else if (deferral_check_enable_q &&
                         defer_cnt_q >= DEFER_LIMIT[14:0]) begin
                o_tx_abort   <= 1'b1;
                abort_seen_q <= 1'b1;
                defer_cnt_q  <= 15'h0000;
            end else if (defer_cnt_q < DEFER_LIMIT[14:0]) begin
                defer_cnt_q <= defer_cnt_q + 15'h0001;
            end
            // Start only when enabled and carrier is clear
            if (transmitter_enable_q && i_tx_frame_ready && !crs_s) begin
                o_tx_start <= 1'b1;
            end
        end
    end

    // Address byte stream, lower byte 0 first
    // A next pulse moves the index at its edge; the matching byte shows
    // one edge after that, so the far side waits two clocks per byte
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wire_idx_q   <= 3'h0;
            o_wire_byte  <= 8'h00;
            o_wire_valid <= 1'b0;
        end else begin
            o_wire_valid <= 1'b1;
            case (wire_idx_q)
                3'h0: o_wire_byte <= station_address_lower_q[7:0];
                3'h1: o_wire_byte <= station_address_lower_q[15:8];
                3'h2: o_wire_byte <= station_address_lower_q[23:16];
                3'h3: o_wire_byte <= station_address_lower_q[31:24];
                3'h4: o_wire_byte <= station_address_upper_q[7:0];
                default: o_wire_byte <= station_address_upper_q[15:8];
            endcase
            if (i_wire_next) begin
                wire_idx_q <= (wire_idx_q == 3'h5) ? 3'h0 : wire_idx_q + 3'h1;
            end
        end
    end
endmodule // mesa_core

// ===== tb/mesa_core_properties.sv
// Checker for mesa_core: APB handshake, enables, deferral abort.
// Bound to mesa_core; sees only its ports.
`timescale 1ns/1ns
module mesa_core_properties #(parameter DEFER_LIMIT = 20) (
    input wire        i_sys_clk, i_rst, i_psel, i_penable, i_pwrite,
    input wire [7:0]  i_paddr,
    input wire [31:0] o_prdata,
    input wire        o_pready, o_pslverr, i_crs, i_tx_frame_ready,
    input wire        i_tx_collision, i_rx_frame_valid, o_tx_start,
    input wire        o_tx_abort, o_rx_accept, o_tx_enabled, o_rx_enabled
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic [15:0] dcnt_q;  // Deferral length seen at the inputs
    // Restarts on collision or when the frame stops waiting
    always @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) dcnt_q <= 16'h0000;
        else if (i_tx_frame_ready && i_crs && !i_tx_collision)
            dcnt_q <= dcnt_q + 16'h0001;
        else dcnt_q <= 16'h0000;
    end
    sequence s_access; i_psel && i_penable && !o_pready; endsequence
    sequence s_rx_held;
        (o_rx_enabled && i_rx_frame_valid)[*2] ##1 o_rx_enabled;
    endsequence
    a_ready_after_access: assert property (s_access |=> o_pready)
        else $error("pready missing after access");
    a_ready_one_pulse: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_error_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    a_reserved_read_zero: assert property (o_pready && !i_pwrite &&
        i_paddr == 8'h08 |-> o_prdata[31:16] == 16'h0000)
        else $error("reserved upper bits not zero");
    a_tx_start_cause: assert property (o_tx_start |->
        $past(i_tx_frame_ready) && (o_tx_enabled || $past(o_tx_enabled)))
        else $error("transmit start without cause");
    a_tx_off_quiet: assert property (!o_tx_enabled &&
        $past(!o_tx_enabled) |-> !o_tx_start)
        else $error("transmit start while disabled");
    a_rx_accept_on: assert property (s_rx_held |-> o_rx_accept)
        else $error("frame not accepted");
    a_accept_needs_frame: assert property (o_rx_accept |->
        $past(i_rx_frame_valid)) else $error("accept without frame");
    a_abort_after_limit: assert property (o_tx_abort |->
        $past(dcnt_q) >= DEFER_LIMIT) else $error("abort too early");
endmodule // mesa_core_properties
bind mesa_core mesa_core_properties #(.DEFER_LIMIT(DEFER_LIMIT)) u_props (
    .i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .o_prdata, .o_pready, .o_pslverr, .i_crs, .i_tx_frame_ready,
    .i_tx_collision, .i_rx_frame_valid, .o_tx_start, .o_tx_abort,
    .o_rx_accept, .o_tx_enabled, .o_rx_enabled);

// ===== tb/mesa_phy_model.sv
// PHY side model: carrier, collision, receive frames, address bytes.
// Assumes the bench commands carrier and collisions on the same clock.
`timescale 1ns/1ns
module mesa_phy_model (
    input wire         i_clk, i_busy, i_collide, i_send, i_listen,
    input wire         i_wire_valid,
    input wire [7:0]   i_wire_byte,
    output logic       o_crs, o_collision, o_frame_valid, o_wire_next,
    output logic [47:0] o_addr_seen
);
    logic [2:0] cnt;  // Address bytes collected
    logic [1:0] gap;  // Clocks left until the next byte has settled
    initial {o_crs, o_collision, o_frame_valid, o_wire_next, cnt, gap} = '0;
    initial o_addr_seen = '0;
    // First byte lands in the low end; stops after six. After each next
    // pulse the block needs two edges before the new byte stands.
    always @(posedge i_clk) begin
        o_crs <= i_busy;
        o_collision <= i_collide;
        o_frame_valid <= i_send;
        o_wire_next <= 1'b0;
        if (!i_listen) begin
            cnt <= 3'd0;
            gap <= 2'd0;
        end else if (gap != 2'd0) begin
            gap <= gap - 2'd1;
        end else if (i_wire_valid && cnt < 3'd6) begin
            o_addr_seen <= {i_wire_byte, o_addr_seen[47:8]};
            o_wire_next <= 1'b1;
            cnt <= cnt + 3'd1;
            gap <= 2'd2;
        end
    end
endmodule // mesa_phy_model

// ===== tb/testbench.sv
// Self-checking bench for mesa_core with a PHY model and APB tasks.
// Assumes a short deferral limit for run time.
`timescale 1ns/1ns
module testbench;
    localparam LIM = 20;
    logic i_sys_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic i_ee_valid = 0, i_ee_done = 0, i_tx_frame_ready = 0, i_wire_next;
    logic i_crs, i_tx_collision, i_rx_frame_valid, serr;
    logic [7:0] i_paddr = 0, i_ee_loc = 0, i_ee_byte = 0, o_wire_byte;
    logic [31:0] i_pwdata = 0, o_prdata, rd;
    logic o_pready, o_pslverr, o_tx_start, o_tx_abort, o_rx_accept;
    logic o_tx_enabled, o_rx_enabled, o_wire_valid;
    logic busy = 0, collide = 0, send = 0, listen = 0;
    logic [47:0] seen;
    int num_errors = 0, samples_checked = 0, aborts = 0, n, k;
    mesa_core #(.DEFER_LIMIT(LIM)) dut (.i_sys_clk, .i_rst, .i_psel,
        .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
        .o_pslverr, .i_ee_valid, .i_ee_loc, .i_ee_byte, .i_ee_done, .i_crs,
        .i_tx_frame_ready, .i_tx_collision, .i_rx_frame_valid, .o_tx_start,
        .o_tx_abort, .o_rx_accept, .o_tx_enabled, .o_rx_enabled,
        .o_wire_byte, .o_wire_valid, .i_wire_next);
    mesa_phy_model phy (.i_clk(i_sys_clk), .i_busy(busy),
        .i_collide(collide), .i_send(send), .i_listen(listen),
        .i_wire_valid(o_wire_valid), .i_wire_byte(o_wire_byte),
        .o_crs(i_crs), .o_collision(i_tx_collision),
        .o_frame_valid(i_rx_frame_valid), .o_wire_next(i_wire_next),
        .o_addr_seen(seen));
    initial forever #50 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) if (o_tx_abort === 1'b1) aborts <= aborts + 1;
    task chk(input string what, input [47:0] exp, got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; waits for pready, only the watchdog ends a hang
    task apb(input logic w, input [7:0] a, input [31:0] d);
        @(posedge i_sys_clk);
        i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do @(posedge i_sys_clk);
        while (o_pready !== 1'b1);
        rd = o_prdata;
        serr = o_pslverr;
        i_psel <= 1'b0; i_penable <= 1'b0;
    endtask
    task t_reset;
        apb(1'b1, 8'h08, 32'h00001234);
        apb(1'b0, 8'h08, 32'h0); chk("upper", 48'hFFFF, rd);
        apb(1'b0, 8'h0C, 32'h0); chk("lower", 48'hFFFFFFFF, rd);
        apb(1'b0, 8'h04, 32'h0); chk("ctrl", 48'h0, rd);
        apb(1'b0, 8'h10, 32'h0); chk("unmapped", 48'h1, serr);
        $display("test reset done");
    endtask
    task t_load;
        for (k = 1; k <= 6; k++) begin
            @(posedge i_sys_clk);
            i_ee_valid <= 1'b1; i_ee_loc <= 8'(k); i_ee_byte <= 8'(k * 17);
        end
        @(posedge i_sys_clk);
        i_ee_valid <= 1'b0; i_ee_done <= 1'b1;
        apb(1'b0, 8'h08, 32'h0); chk("upper", 48'h6655, rd);
        apb(1'b0, 8'h0C, 32'h0); chk("lower", 48'h44332211, rd);
        listen <= 1'b1;
        for (n = 0; n < 40 && seen !== 48'h665544332211; n++)
            @(posedge i_sys_clk);
        chk("wire", 48'h665544332211, seen);
        listen <= 1'b0;
        apb(1'b1, 8'h08, 32'hABCD5AA5);
        apb(1'b0, 8'h08, 32'h0); chk("upper", 48'h5AA5, rd);
        $display("test load done");
    endtask
    task t_enable;
        apb(1'b1, 8'h04, 32'h0000000C);
        i_tx_frame_ready <= 1'b1; send <= 1'b1;
        for (n = 0; n < 20 && !(o_tx_start === 1'b1 && o_rx_accept === 1'b1);
            n++) @(posedge i_sys_clk);
        chk("start", 48'h1, o_tx_start);
        chk("accept", 48'h1, o_rx_accept);
        chk("tx on", 48'h1, o_tx_enabled);
        chk("rx on", 48'h1, o_rx_enabled);
        apb(1'b1, 8'h04, 32'h0);
        n = 0;
        repeat (10) begin
            @(posedge i_sys_clk);
            n += (o_tx_start !== 1'b0);
        end
        chk("quiet", 48'h0, n);
        chk("tx off", 48'h0, o_tx_enabled);
        i_tx_frame_ready <= 1'b0; send <= 1'b0;
        $display("test enable done");
    endtask
    task t_defer;
        apb(1'b1, 8'h04, 32'h00000028);
        busy <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        i_tx_frame_ready <= 1'b1;
        repeat (15) @(posedge i_sys_clk);
        collide <= 1'b1;
        @(posedge i_sys_clk);
        collide <= 1'b0;
        n = aborts;
        for (k = 0; k < 60 && aborts == n; k++) @(posedge i_sys_clk);
        chk("abort", 48'h1, aborts > n);
        chk("restart", 48'h1, k >= LIM);
        apb(1'b1, 8'h04, 32'h00000008);
        repeat (2) @(posedge i_sys_clk);
        n = aborts;
        repeat (60) @(posedge i_sys_clk);
        chk("no abort", 48'(n), 48'(aborts));
        apb(1'b0, 8'h1C, 32'h0);
        chk("status", 48'h7, rd);
        busy <= 1'b0; i_tx_frame_ready <= 1'b0;
        $display("test defer done");
    endtask
    task test_done;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        t_reset; t_load; t_enable; t_defer;
        test_done;
    end
    initial begin
        repeat (3000) @(posedge i_sys_clk);
        num_errors++;
        test_done;
    end
endmodule // testbench
